// >>> logic/sfrid_pkg.sv
package sfrid_pkg;

  // opcodes seen on the serial input, most significant bit first
  localparam logic [7:0] NO_OPERATION_CMD       = 8'h00;
  localparam logic [7:0] RESET_ENABLE_CMD       = 8'h66;
  localparam logic [7:0] RESET_CMD              = 8'h99;
  localparam logic [7:0] UNIQUE_ID_READ_CMD     = 8'h4b;
  localparam logic [7:0] PARAMETER_TABLE_READ_CMD = 8'h5a;

  // frame phase lengths in serial clock bits
  localparam logic [6:0] OP_BITS        = 7'h08;
  localparam logic [6:0] ADDR_BITS      = 7'h18;
  localparam logic [6:0] UID_DUMMY_BITS = 7'h20;
  localparam logic [6:0] TBL_DUMMY_BITS = 7'h08;
  localparam int         UID_BITS       = 128;

  // recovery after a software reset
  localparam int CLK_MHZ   = 200;
  localparam int RECOV_NS  = 1000;
  localparam int RECOV_CYC = (RECOV_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOV_W   = 16;

  // reset value of the table address
  localparam logic [23:0] ADDR_RESET = 24'h000000;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_UDUM,
    ST_TDUM,
    ST_UID,
    ST_TBL,
    ST_SKIP
  } sfrid_state_e;

endpackage

// >>> logic/sfrid_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser; only the second stage leaves the module
module sfrid_sync #(
  parameter int              W        = 1,
  parameter logic [W-1:0]    RST_VAL  = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // sfrid_sync

// >>> logic/sfrid_cmd.sv
`timescale 1ns/10ps
module sfrid_cmd
  import sfrid_pkg::*;
#(
  parameter logic [UID_BITS-1:0] UNIQUE_ID = 128'h0123456789abcdeffedcba9876543210
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        si,
  input  wire logic [2:0]  upper_data_lines_in,
  input  wire logic        pe_busy,
  input  wire logic        pe_suspended,
  input  wire logic [7:0]  table_data,
  output logic             so_out,
  output logic             so_oe,
  output logic [23:0]      table_addr,
  output logic             soft_reset,
  output logic             pe_abort,
  output logic             reset_armed,
  output logic             recovering
);

  typedef struct packed {
    sfrid_state_e       st;
    logic [6:0]         cnt;
    logic [7:0]         sr;
    logic [23:0]        addr;
    logic [7:0]         obyte;
    logic               armed;
    logic               so;
    logic               oe;
    logic               sreset;
    logic               abort;
    logic               sck_q;
    logic [RECOV_W-1:0] recov;
  } sfrid_regs_s;

  sfrid_regs_s s_reg;
  sfrid_regs_s s_next;
  logic        cs_n_s;
  logic        sck_s;
  logic        si_s;
  logic        sck_rise;
  logic        sck_fall;
  logic [7:0]  op_byte;
  logic        op_done;

  // upper data lines are never sampled by this block
  sfrid_sync #(
    .W       (3),
    .RST_VAL (3'h5)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({cs_n, sck, si}),
    .q   ({cs_n_s, sck_s, si_s})
  );

  // link edges found on the synchronised serial clock
  assign sck_rise = sck_s & ~s_reg.sck_q;
  assign sck_fall = ~sck_s & s_reg.sck_q;
  assign op_byte  = {s_reg.sr[6:0], si_s};
  assign op_done  = ~cs_n_s & sck_rise & (s_reg.st == ST_CMD)
                    & (s_reg.cnt == OP_BITS - 7'h01);

  function automatic logic uid_bit(input logic [6:0] idx);
    uid_bit = UNIQUE_ID[7'h7f - idx];
  endfunction

  // next-state logic of the whole frame decoder
  always_comb begin
    s_next        = s_reg;
    s_next.sreset = 1'b0;
    s_next.abort  = 1'b0;
    s_next.sck_q  = sck_s;
    if (s_reg.recov != '0) begin
      s_next.recov = s_reg.recov - 16'h0001;
    end
    if (cs_n_s) begin
      // deselect ends every command at once, mid-byte too
      s_next.st  = ST_CMD;
      s_next.cnt = 7'h00;
      s_next.oe  = 1'b0;
    end else if (sck_rise) begin
      s_next.cnt = s_reg.cnt + 7'h01;
      case (s_reg.st)
        ST_CMD: begin
          s_next.sr = op_byte;
          if (op_done) begin
            s_next.cnt = 7'h00;
            s_next.st  = ST_SKIP;
            if (s_reg.recov != '0) begin
              s_next.st = ST_SKIP;
            end else if (op_byte == RESET_ENABLE_CMD) begin
              // accepted whatever the suspend state
              s_next.armed = 1'b1;
            end else if (op_byte == RESET_CMD && s_reg.armed) begin
              s_next.sreset = 1'b1;
              s_next.abort  = pe_busy;
              s_next.armed  = 1'b0;
              s_next.addr   = ADDR_RESET;
              s_next.recov  = RECOV_CYC[RECOV_W-1:0];
            end else begin
              // no-operation, lone reset or any other opcode
              s_next.armed = 1'b0;
              if (op_byte == UNIQUE_ID_READ_CMD) begin
                s_next.st = ST_UDUM;
              end else if (op_byte == PARAMETER_TABLE_READ_CMD) begin
                s_next.st = ST_ADDR;
              end
            end
          end
        end
        ST_ADDR: begin
          s_next.addr = {s_reg.addr[22:0], si_s};
          if (s_reg.cnt == ADDR_BITS - 7'h01) begin
            s_next.cnt = 7'h00;
            s_next.st  = ST_TDUM;
          end
        end
        ST_UDUM: begin
          if (s_reg.cnt == UID_DUMMY_BITS - 7'h01) begin
            s_next.cnt = 7'h00;
            s_next.st  = ST_UID;
          end
        end
        ST_TDUM: begin
          if (s_reg.cnt == TBL_DUMMY_BITS - 7'h01) begin
            s_next.cnt = 7'h00;
            s_next.st  = ST_TBL;
          end
        end
        default: begin
          s_next.cnt = s_reg.cnt;
        end
      endcase
    end else if (sck_fall) begin
      case (s_reg.st)
        ST_UID: begin
          // wraps after bit 0 and repeats until deselect
          s_next.oe  = 1'b1;
          s_next.so  = uid_bit(s_reg.cnt);
          s_next.cnt = s_reg.cnt + 7'h01;
        end
        ST_TBL: begin
          // table data is looked up one byte ahead: addr steps as each byte loads
          s_next.oe  = 1'b1;
          s_next.cnt = {4'h0, s_reg.cnt[2:0] + 3'h1};
          if (s_reg.cnt[2:0] == 3'h0) begin
            s_next.so    = table_data[7];
            s_next.obyte = {table_data[6:0], 1'b0};
            s_next.addr  = s_reg.addr + 24'h000001;
          end else begin
            s_next.so    = s_reg.obyte[7];
            s_next.obyte = {s_reg.obyte[6:0], 1'b0};
          end
        end
        default: begin
          s_next.oe = s_reg.oe;
        end
      endcase
    end
  end

  // single register stage for all decoder state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: ST_CMD, cnt: 7'h00, sr: 8'h00, addr: ADDR_RESET,
                 obyte: 8'h00, armed: 1'b0, so: 1'b0, oe: 1'b0,
                 sreset: 1'b0, abort: 1'b0, sck_q: 1'b0,
                 recov: 16'h0000};
    end else begin
      s_reg <= s_next;
    end
  end

  assign so_out      = s_reg.so;
  assign so_oe       = s_reg.oe;
  assign table_addr  = s_reg.addr;
  assign soft_reset  = s_reg.sreset;
  assign pe_abort    = s_reg.abort;
  assign reset_armed = s_reg.armed;
  assign recovering  = (s_reg.recov != '0);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_arm_taken;
    op_done && op_byte == RESET_ENABLE_CMD && s_reg.recov == '0;
  endsequence

  sequence s_other_taken;
    op_done && op_byte != RESET_ENABLE_CMD && op_byte != RESET_CMD
      && s_reg.recov == '0;
  endsequence

  property p_nop_cancels;
    op_done && op_byte == NO_OPERATION_CMD && s_reg.recov == '0
      |=> !reset_armed && !soft_reset;
  endproperty
  a_nop_cancels: assert property (p_nop_cancels)
    else $error("no-operation left reset armed");

  property p_arm;
    s_arm_taken |=> reset_armed;
  endproperty
  a_arm: assert property (p_arm)
    else $error("reset-enable did not arm");

  property p_reset_needs_arm;
    $rose(soft_reset) |-> $past(reset_armed) && $past(op_done)
      && $past(op_byte) == RESET_CMD;
  endproperty
  a_reset_needs_arm: assert property (p_reset_needs_arm)
    else $error("reset without prior reset-enable");

  property p_other_cancels;
    s_other_taken |=> !reset_armed ##1 !soft_reset;
  endproperty
  a_other_cancels: assert property (p_other_cancels)
    else $error("other command kept reset armed");

  property p_reset_clears;
    soft_reset |-> !reset_armed && recovering && !so_oe
      && table_addr == ADDR_RESET;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("software reset left state behind");

  property p_abort;
    soft_reset |-> pe_abort == $past(pe_busy);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort does not follow busy at reset");

  // abort must never fire on its own, only with the reset pulse
  property p_abort_only_reset;
    pe_abort |-> soft_reset;
  endproperty
  a_abort_only_reset: assert property (p_abort_only_reset)
    else $error("abort pulse without software reset");

  property p_uid_bits;
    !cs_n_s && sck_fall && s_reg.st == ST_UID
      |=> so_oe && so_out == UNIQUE_ID[7'h7f - $past(s_reg.cnt)];
  endproperty
  a_uid_bits: assert property (p_uid_bits)
    else $error("identifier bit wrong");

  property p_cs_release;
    cs_n_s |=> !so_oe ##1 !so_oe;
  endproperty
  a_cs_release: assert property (p_cs_release)
    else $error("output driven after deselect");

  property p_suspend_arm;
    pe_suspended ##0 s_arm_taken |=> reset_armed;
  endproperty
  a_suspend_arm: assert property (p_suspend_arm)
    else $error("reset-enable refused while suspended");

  property p_recov_ignore;
    op_done && recovering |=> $stable(reset_armed) && !soft_reset;
  endproperty
  a_recov_ignore: assert property (p_recov_ignore)
    else $error("command decoded during recovery");

endmodule // sfrid_cmd

// >>> verification/sfrid_host.sv
`timescale 1ns/10ps
// host controller model, mode 0: sck idles low outside frames
module sfrid_host (
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so_out
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // frame opens with select low
  task automatic start();
    cs_n = 1'b0;
    #32;
  endtask
  // msb first, one bit per 64 ns sck period
  task automatic put(input logic [31:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      si = d[i];
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
  endtask
  // sample on sck rise; si toggles so no stale level lingers
  task automatic get(input int n, output logic [135:0] r);
    r = '0;
    for (int i = 0; i < n; i++) begin
      si = ~si;
      #32 sck = 1'b1;
      r = {r[134:0], so_out};
      #32 sck = 1'b0;
    end
  endtask
  // select high ends any frame, held well past 4 clk
  task automatic stop();
    #32 cs_n = 1'b1;
    si = ~si;
    #64;
  endtask
endmodule // sfrid_host

// >>> verification/tb_serial_flash_reset_id_sfdp.sv
`timescale 1ns/10ps
module tb_serial_flash_reset_id_sfdp;
  import sfrid_pkg::*;
  // arbitrary identifier value for this bench
  localparam logic [127:0] ID = 128'h5a3c96e10f7bd248c6e51a903b7f24d8;
  logic clk = 1'b0, rst = 1'b1, pe_busy = 1'b0, pe_susp = 1'b0;
  logic cs_n, sck, si, so_out, so_oe, soft_reset, pe_abort, so_line;
  logic reset_armed, recovering;
  logic [2:0]   up = 3'h0;
  logic [7:0]   table_data, b0, b1;
  logic [23:0]  table_addr;
  logic [31:0]  rnd = 32'h606e;
  logic [135:0] r;
  logic         exp_q[$];
  int num_errors = 0, samples_checked = 0, cyc = 0;

  always #2.5 clk = ~clk;
  // table byte follows address, valid by the next cycle
  assign table_data = table_addr[7:0] ^ 8'ha5;
  // released line reads inverted, so a missing enable shows up
  assign so_line = so_oe ? so_out : ~so_out;

  sfrid_host i_sfrid_host (.cs_n(cs_n), .sck(sck), .si(si),
    .so_out(so_line));
  sfrid_cmd #(.UNIQUE_ID(ID)) i_sfrid_cmd (.clk(clk), .rst(rst),
    .cs_n(cs_n), .sck(sck), .si(si), .upper_data_lines_in(up),
    .pe_busy(pe_busy), .pe_suspended(pe_susp), .table_data(table_data),
    .so_out(so_out), .so_oe(so_oe), .table_addr(table_addr),
    .soft_reset(soft_reset), .pe_abort(pe_abort),
    .reset_armed(reset_armed), .recovering(recovering));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [135:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one short frame; upper lines carry junk throughout
  task automatic cmd(input logic [7:0] op);
    @(posedge clk);
    #1;
    rnd = xs(rnd);
    up = rnd[2:0];
    i_sfrid_host.start();
    i_sfrid_host.put({24'h0, op}, 8);
    i_sfrid_host.stop();
  endtask

  // each reset pulse takes the oldest expected abort flag
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      num_errors++;
      finish_test();
    end else if (soft_reset === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0, "stray reset");
      else check(pe_abort, exp_q.pop_front(), "abort flag");
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    check({so_oe, soft_reset, reset_armed}, 3'h0, "idle");
    // two-step reset while a program runs
    pe_busy = 1'b1;
    cmd(RESET_ENABLE_CMD);
    check(reset_armed, 1'b1, "armed");
    exp_q.push_back(1'b1);
    cmd(RESET_CMD);
    check({reset_armed, recovering}, 2'h1, "recover");
    cmd(RESET_ENABLE_CMD);
    check(reset_armed, 1'b0, "busy ignore");
    repeat (250) @(posedge clk);
    #1 pe_busy = 1'b0;
    $display("test reset done");
    // no-operation drops the arm, later reset does nothing
    cmd(RESET_ENABLE_CMD);
    cmd(NO_OPERATION_CMD);
    check(reset_armed, 1'b0, "nop");
    cmd(RESET_CMD);
    $display("test cancel done");
    // id read after an arm: arm dropped, id wraps
    cmd(RESET_ENABLE_CMD);
    i_sfrid_host.start();
    i_sfrid_host.put({24'h0, UNIQUE_ID_READ_CMD}, 8);
    i_sfrid_host.put(32'h0, 32);
    i_sfrid_host.get(136, r);
    check(r, {ID, ID[127:120]}, "id");
    check(so_oe, 1'b1, "id drive");
    i_sfrid_host.stop();
    check({so_oe, reset_armed}, 2'h0, "after id");
    $display("test id done");
    // table read at a random address, cut mid-byte
    rnd = xs(rnd);
    b0 = rnd[7:0] ^ 8'ha5;
    b1 = (rnd[7:0] + 8'h01) ^ 8'ha5;
    i_sfrid_host.start();
    i_sfrid_host.put({PARAMETER_TABLE_READ_CMD, rnd[23:0]}, 32);
    i_sfrid_host.put(rnd[31:24], 8);
    i_sfrid_host.get(12, r);
    check(r, {b0, b1[7:4]}, "table");
    i_sfrid_host.stop();
    check(so_oe, 1'b0, "table end");
    $display("test table done");
    // reset while suspended, nothing to abort
    @(posedge clk);
    #1 pe_susp = 1'b1;
    cmd(RESET_ENABLE_CMD);
    exp_q.push_back(1'b0);
    cmd(RESET_CMD);
    repeat (250) @(posedge clk);
    check(136'(exp_q.size()), '0, "reset count");
    $display("test suspend done");
    finish_test();
  end
endmodule // tb_serial_flash_reset_id_sfdp
